/* File: pcs_defines.svh */
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH

// register byte offsets
`define PCS_OFF_PLLC 8'h00
`define PCS_OFF_POWER 8'h04
`define PCS_OFF_STATUS 8'h08
`define PCS_ADDR_W 8

// pll control fields
`define PCS_PLLC_W 16
`define PCS_PLLC_RST 16'h0000
`define PCS_M_LSB 0
`define PCS_M_MSB 4
`define PCS_N_LSB 5
`define PCS_N_MSB 7
`define PCS_LF_LSB 8
`define PCS_LF_MSB 11
`define PCS_EN_BIT 15
`define PCS_SEL_BIT 14

// power control fields
`define PCS_POWER_W 2
`define PCS_POWER_RST 2'h0
`define PCS_NOCK_BIT 0
`define PCS_SLOW_BIT 1

// status fields
`define PCS_ST_LOCK_BIT 0
`define PCS_ST_SRC_LSB 1
`define PCS_ST_SRC_MSB 2
`define PCS_ST_PWR_BIT 3
`define PCS_ST_BUSY_BIT 4

// divider coding
`define PCS_N_ONE_CODE 3'h7
`define PCS_DIV_OFFSET 6'h02
`define PCS_N_ONE 6'h01

// timing
`define PCS_CLK_PERIOD_NS 10
`define PCS_LOCK_TIME_NS 2000
`define PCS_LOCK_CYCLES (16'((`PCS_LOCK_TIME_NS + `PCS_CLK_PERIOD_NS - 1) / `PCS_CLK_PERIOD_NS))

// ahb-lite
`define PCS_HTRANS_NONSEQ 2'h2
`define PCS_HTRANS_SEQ 2'h3

`endif

/* File: pcs_pkg.sv */
`default_nettype none

package pcs_pkg;

  typedef enum logic [1:0] {
    PCS_SRC_REF = 2'h0,
    PCS_SRC_SYNTH = 2'h1,
    PCS_SRC_RING = 2'h2,
    PCS_SRC_STOP = 2'h3
  } pcs_src_t;

  typedef enum logic [2:0] {
    PCS_ST_REF = 3'h0,
    PCS_ST_TO_SYN = 3'h1,
    PCS_ST_SYN = 3'h2,
    PCS_ST_FROM_SYN = 3'h3,
    PCS_ST_RING = 3'h4,
    PCS_ST_STOP = 3'h5
  } pcs_fsm_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic detect_on;
    logic locked;
    logic lock_pulse;
  } pcs_lock_state_t;

endpackage : pcs_pkg

`default_nettype wire

/* File: pcs_synth_if.sv */
`default_nettype none

interface pcs_synth_if;
  logic enable;
  logic restart;
  logic [5:0] m_val;
  logic locked;
  logic lock_pulse;

  modport ctrl (output enable, output restart, output m_val, input locked, input lock_pulse);
  modport synth (input enable, input restart, input m_val, output locked, output lock_pulse);
endinterface : pcs_synth_if

`default_nettype wire

/* File: pcs_lock_detect.sv */
`include "pcs_defines.svh"
`default_nettype none

// acquisition model of the synthesizer loop; detector shuts off once locked
module pcs_lock_detect (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control side
  pcs_synth_if.synth sif
);

  pcs_pkg::pcs_lock_state_t st_q;
  pcs_pkg::pcs_lock_state_t st_d;
  logic [15:0] target;

  assign target = `PCS_LOCK_CYCLES + {10'h000, sif.m_val};

  always_comb begin
    st_d = st_q;
    st_d.lock_pulse = 1'b0;
    if (!sif.enable || sif.restart) begin // RULE7 RULE12 RULE19
      st_d.cnt = 16'h0000;
      st_d.locked = 1'b0;
      st_d.detect_on = sif.enable;
    end else if (st_q.detect_on) begin
      if (st_q.cnt >= target - 16'h0001) begin
        st_d.locked = 1'b1;
        st_d.detect_on = 1'b0; // RULE4
        st_d.lock_pulse = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sif.locked = st_q.locked;
  assign sif.lock_pulse = st_q.lock_pulse;

endmodule : pcs_lock_detect

`default_nettype wire

/* File: pcs_clock_ctrl.sv */
// Chosen here: the register offsets and the AHB-Lite register port.
`include "pcs_defines.svh"
`default_nettype none

//Contract
// [RULE1] after reset clock runs from input clock
// [RULE2] three sources: input, synthesizer, ring oscillator
// [RULE3] power register overrides: stop or ring clock
// [RULE4] on lock set flag, stop detection
// [RULE5] select bit moves clock to synthesizer cleanly
// [RULE6] any control write clears lock flag; a control write in the same cycle as the lock pulse leaves it set
// [RULE7] changed settings restart loop acquisition
// [RULE8] 3-bit N, 5-bit M dividers
// [RULE9] M and N coded minus two; N=1 is 7
// [RULE10] software keeps oscillator at twice input
// [RULE11] software programs loop filter bits
// [RULE12] enable bit powers synthesizer up or down
// [RULE13] select clear input clock, set synthesizer
// [RULE14] reset clears whole control register
// [RULE15] software changes dividers only when deselected
// [RULE16] software checks lock before selecting synthesizer
// [RULE17] software waits relock before reselecting
// [RULE18] software powers synthesizer down before clock stops
// [RULE19] synthesizer needs the input clock
// [RULE20] switch to synthesizer within 1..N+2 cycles
// [RULE21] switch back within M/N+1..M+M/N+1 cycles
// [RULE22] lock flag readable, writes only clear it
module pcs_clock_ctrl (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // clock source status
  output logic [1:0] clk_src,
  output logic synth_power,
  output logic ring_osc_en,
  output logic synth_lock,
  output logic [5:0] synth_m,
  output logic [5:0] synth_n
);

  typedef struct packed {
    logic [`PCS_PLLC_W-1:0] pllc;
    logic [`PCS_POWER_W-1:0] power;
    logic lock_flag;
    logic restart;
    pcs_pkg::pcs_fsm_t fsm;
    logic [6:0] wait_cnt;
    logic [1:0] src;
    logic ring_en;
    logic [5:0] m_val;
    logic [5:0] n_val;
    logic dp_write;
    logic [`PCS_ADDR_W-1:0] dp_addr;
    logic [31:0] rdata;
  } pcs_ctrl_state_t;

  pcs_ctrl_state_t st_q;
  pcs_ctrl_state_t st_d;

  pcs_synth_if sif ();

  pcs_lock_detect u_lock (
    .hclk(hclk),
    .hresetn(hresetn),
    .sif(sif)
  );

  // field views of the held control value
  logic [2:0] n_code;
  logic [4:0] m_code;
  logic synth_en;
  logic synth_sel;
  logic nock;
  logic slow;
  logic [5:0] n_dec;
  logic [5:0] m_dec;
  logic [5:0] m_over_n;
  logic [6:0] to_syn_wait;
  logic [6:0] from_syn_wait;

  assign n_code = st_q.pllc[`PCS_N_MSB:`PCS_N_LSB];
  assign m_code = st_q.pllc[`PCS_M_MSB:`PCS_M_LSB];
  assign synth_en = st_q.pllc[`PCS_EN_BIT];
  assign synth_sel = st_q.pllc[`PCS_SEL_BIT];
  assign nock = st_q.power[`PCS_NOCK_BIT];
  assign slow = st_q.power[`PCS_SLOW_BIT];

  // divider decode
  always_comb begin
    if (n_code == `PCS_N_ONE_CODE) begin // RULE9
      n_dec = `PCS_N_ONE;
    end else begin
      n_dec = {3'h0, n_code} + `PCS_DIV_OFFSET;
    end
    m_dec = {1'h0, m_code} + `PCS_DIV_OFFSET; // RULE8 RULE9
    m_over_n = m_dec / n_dec;
  end

  // switch latencies: n+1 toward synthesizer, m/n+1 away from it
  assign to_syn_wait = {1'h0, n_dec} + 7'h01; // RULE20
  assign from_syn_wait = {1'h0, m_over_n} + 7'h01; // RULE21

  // connection to the loop model
  assign sif.enable = synth_en; // RULE12
  assign sif.restart = st_q.restart;
  assign sif.m_val = st_q.m_val;

  // bus decode
  logic addr_phase;
  logic [`PCS_ADDR_W-1:0] ap_addr;
  logic wr_pllc;
  logic wr_power;
  logic [`PCS_PLLC_W-1:0] new_pllc;

  assign addr_phase = hsel && hready && (htrans == `PCS_HTRANS_NONSEQ || htrans == `PCS_HTRANS_SEQ);
  assign ap_addr = haddr[`PCS_ADDR_W-1:0];
  assign wr_pllc = st_q.dp_write && (st_q.dp_addr == `PCS_OFF_PLLC);
  assign wr_power = st_q.dp_write && (st_q.dp_addr == `PCS_OFF_POWER);
  assign new_pllc = hwdata[`PCS_PLLC_W-1:0];

  // requested source, power register first
  pcs_pkg::pcs_src_t req_src;

  always_comb begin
    if (nock) begin // RULE3
      req_src = pcs_pkg::PCS_SRC_STOP;
    end else if (slow) begin // RULE3
      req_src = pcs_pkg::PCS_SRC_RING;
    end else if (synth_sel) begin // RULE13
      req_src = pcs_pkg::PCS_SRC_SYNTH;
    end else begin
      req_src = pcs_pkg::PCS_SRC_REF;
    end
  end

  // status word
  logic [31:0] status_word;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`PCS_ST_LOCK_BIT] = st_q.lock_flag; // RULE22
    status_word[`PCS_ST_SRC_MSB:`PCS_ST_SRC_LSB] = st_q.src;
    status_word[`PCS_ST_PWR_BIT] = synth_en;
    status_word[`PCS_ST_BUSY_BIT] = (st_q.fsm == pcs_pkg::PCS_ST_TO_SYN) ||
                                    (st_q.fsm == pcs_pkg::PCS_ST_FROM_SYN);
  end

  always_comb begin
    st_d = st_q;
    st_d.restart = 1'b0;
    st_d.m_val = m_dec;
    st_d.n_val = n_dec;

    // address phase capture
    st_d.dp_write = addr_phase && hwrite;
    st_d.dp_addr = ap_addr;
    if (addr_phase && !hwrite) begin
      case (ap_addr)
        `PCS_OFF_PLLC: begin
          st_d.rdata = {16'h0000, st_q.pllc};
        end
        `PCS_OFF_POWER: begin
          st_d.rdata = {30'h0, st_q.power};
        end
        `PCS_OFF_STATUS: begin
          st_d.rdata = status_word;
        end
        default: begin
          st_d.rdata = 32'h0000_0000;
        end
      endcase
    end else begin
      st_d.rdata = 32'h0000_0000;
    end

    // data phase writes
    if (wr_pllc) begin
      st_d.pllc = new_pllc; // RULE7
      // any change of settings or enable makes the loop reacquire
      if (new_pllc[`PCS_SEL_BIT-1:0] != st_q.pllc[`PCS_SEL_BIT-1:0] ||
          new_pllc[`PCS_EN_BIT] != st_q.pllc[`PCS_EN_BIT]) begin
        st_d.restart = 1'b1; // RULE7
      end
    end
    if (wr_power) begin
      st_d.power = hwdata[`PCS_POWER_W-1:0];
    end

    // lock flag: the lock event wins over the clearing write
    if (sif.lock_pulse) begin
      st_d.lock_flag = 1'b1; // RULE4
    end else if (wr_pllc) begin
      st_d.lock_flag = 1'b0; // RULE6
    end

    // source switching
    case (st_q.fsm)
      pcs_pkg::PCS_ST_REF: begin
        st_d.src = pcs_pkg::PCS_SRC_REF; // RULE1
        if (req_src == pcs_pkg::PCS_SRC_SYNTH) begin
          st_d.fsm = pcs_pkg::PCS_ST_TO_SYN; // RULE5
          st_d.wait_cnt = to_syn_wait;
        end else if (req_src == pcs_pkg::PCS_SRC_RING) begin
          st_d.fsm = pcs_pkg::PCS_ST_RING;
        end else if (req_src == pcs_pkg::PCS_SRC_STOP) begin
          st_d.fsm = pcs_pkg::PCS_ST_STOP;
        end
      end
      pcs_pkg::PCS_ST_TO_SYN: begin
        // old rate kept until the count runs out
        if (req_src != pcs_pkg::PCS_SRC_SYNTH) begin
          st_d.fsm = pcs_pkg::PCS_ST_REF;
        end else if (st_q.wait_cnt <= 7'h01) begin
          st_d.fsm = pcs_pkg::PCS_ST_SYN; // RULE20
          st_d.src = pcs_pkg::PCS_SRC_SYNTH; // RULE5 RULE13
          st_d.wait_cnt = 7'h00;
        end else begin
          st_d.wait_cnt = st_q.wait_cnt - 7'h01;
        end
      end
      pcs_pkg::PCS_ST_SYN: begin
        st_d.src = pcs_pkg::PCS_SRC_SYNTH;
        if (req_src != pcs_pkg::PCS_SRC_SYNTH) begin
          st_d.fsm = pcs_pkg::PCS_ST_FROM_SYN;
          st_d.wait_cnt = from_syn_wait;
        end
      end
      pcs_pkg::PCS_ST_FROM_SYN: begin
        if (st_q.wait_cnt <= 7'h01) begin
          st_d.fsm = pcs_pkg::PCS_ST_REF; // RULE21
          st_d.src = pcs_pkg::PCS_SRC_REF;
          st_d.wait_cnt = 7'h00;
        end else begin
          st_d.wait_cnt = st_q.wait_cnt - 7'h01;
        end
      end
      pcs_pkg::PCS_ST_RING: begin
        st_d.src = pcs_pkg::PCS_SRC_RING; // RULE2
        if (req_src != pcs_pkg::PCS_SRC_RING) begin
          st_d.fsm = pcs_pkg::PCS_ST_REF;
          st_d.src = pcs_pkg::PCS_SRC_REF;
        end
      end
      pcs_pkg::PCS_ST_STOP: begin
        st_d.src = pcs_pkg::PCS_SRC_STOP; // RULE3
        if (req_src != pcs_pkg::PCS_SRC_STOP) begin
          st_d.fsm = pcs_pkg::PCS_ST_REF;
          st_d.src = pcs_pkg::PCS_SRC_REF;
        end
      end
      default: begin
        st_d.fsm = pcs_pkg::PCS_ST_REF;
        st_d.src = pcs_pkg::PCS_SRC_REF;
      end
    endcase

    // ring oscillator runs while in PCS_ST_RING, starting one cycle before it is the source
    st_d.ring_en = (st_d.fsm == pcs_pkg::PCS_ST_RING);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q.pllc <= `PCS_PLLC_RST; // RULE14
      st_q.power <= `PCS_POWER_RST;
      st_q.lock_flag <= 1'b0;
      st_q.restart <= 1'b0;
      st_q.fsm <= pcs_pkg::PCS_ST_REF; // RULE1
      st_q.wait_cnt <= 7'h00;
      st_q.src <= pcs_pkg::PCS_SRC_REF;
      st_q.ring_en <= 1'b0;
      st_q.m_val <= `PCS_DIV_OFFSET;
      st_q.n_val <= `PCS_DIV_OFFSET;
      st_q.dp_write <= 1'b0;
      st_q.dp_addr <= '0;
      st_q.rdata <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
    end
  end

  assign hrdata = st_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign clk_src = st_q.src;
  assign synth_power = st_q.pllc[`PCS_EN_BIT];
  assign ring_osc_en = st_q.ring_en;
  assign synth_lock = st_q.lock_flag;
  assign synth_m = st_q.m_val;
  assign synth_n = st_q.n_val;

endmodule : pcs_clock_ctrl

`default_nettype wire

/* File: pcs_clock_ctrl_properties.sv */
`default_nettype none

module pcs_props (
  // clock, reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // status
  input wire logic [1:0] clk_src,
  input wire logic synth_power,
  input wire logic ring_osc_en,
  input wire logic synth_lock,
  input wire logic [5:0] synth_m
);
  logic wr_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // high in the data phase of a control write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
    end else begin
      wr_q <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h00;
    end
  end
  a_reset_state: assert property (!$past(hresetn) |-> clk_src == 2'h0 && !synth_power)
    else $error("state after reset");
  a_enable_bit: assert property (wr_q |=> synth_power == $past(hwdata[15]))
    else $error("enable mismatch");
  a_write_clears: assert property (wr_q |=> !synth_lock || !$past(synth_lock))
    else $error("lock not cleared");
  a_lock_kept: assert property ($fell(synth_lock) |-> $past(wr_q))
    else $error("lock lost");
  a_lock_power: assert property ($rose(synth_lock) |-> synth_power)
    else $error("lock unpowered");
  a_m_decode: assert property (
    wr_q |=> ##1 synth_m == 6'($past(hwdata[4:0], 2)) + 6'h02)
    else $error("m decode");
  a_to_synth: assert property (
    wr_q && hwdata[14] && clk_src == 2'h0 && !ring_osc_en |-> ##[1:11] clk_src == 2'h1)
    else $error("slow switch");
  a_from_synth: assert property (
    wr_q && !hwdata[14] && clk_src == 2'h1 |-> ##[1:42] clk_src == 2'h0)
    else $error("slow switch back");
  a_ring_source: assert property (clk_src == 2'h2 [*2] |-> ring_osc_en)
    else $error("ring off");
endmodule : pcs_props

bind pcs_clock_ctrl pcs_props i_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .clk_src(clk_src), .synth_power(synth_power),
  .ring_osc_en(ring_osc_en), .synth_lock(synth_lock), .synth_m(synth_m)
);

`default_nettype wire

/* File: testbench.sv */
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [1:0] clk_src;
  logic synth_power;
  logic ring_osc_en;
  logic synth_lock;
  logic [5:0] synth_m;
  logic [5:0] synth_n;
  logic [31:0] rd;
  int fails = 0;
  int n_checks = 0;
  int n;
  // control word, decoded m, decoded n
  logic [27:0] rows [5] = '{{16'h0000, 6'h02, 6'h02}, {16'h00E0, 6'h02, 6'h01},
    {16'h0012, 6'h14, 6'h02}, {16'h00D2, 6'h14, 6'h08}, {16'h0F25, 6'h07, 6'h03}};

  always #5 hclk = ~hclk;

  pcs_clock_ctrl i_dut (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'h2),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .clk_src(clk_src),
    .synth_power(synth_power),
    .ring_osc_en(ring_osc_en),
    .synth_lock(synth_lock),
    .synth_m(synth_m),
    .synth_n(synth_n)
  );

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask : chk

  // one single transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wlock;
    n = 0;
    while (synth_lock !== 1'b1 && n < 400) begin
      @(negedge hclk);
      n++;
    end
  endtask : wlock

  task automatic wsrc(input logic [1:0] e);
    n = 0;
    while (clk_src !== e && n < 200) begin
      @(negedge hclk);
      n++;
    end
    @(negedge hclk);
  endtask : wsrc

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (3000) @(posedge hclk);
    fails++;
    test_done();
  end

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 8'h00, 32'h0);
    chk("pllc", 32'h0, rd);
    chk("clk_src", 32'h0, 32'(clk_src));
    foreach (rows[i]) begin
      bus(1'b1, 8'h00, {16'h0, rows[i][27:12]});
      bus(1'b0, 8'h00, 32'h0);
      @(negedge hclk);
      chk("pllc", {16'h0, rows[i][27:12]}, rd);
      chk("synth_m", 32'(rows[i][11:6]), 32'(synth_m));
      chk("synth_n", 32'(rows[i][5:0]), 32'(synth_n));
    end
    bus(1'b1, 8'h00, 32'h8012);
    wlock();
    chk("synth_power", 32'h1, 32'(synth_power));
    bus(1'b0, 8'h08, 32'h0);
    chk("status lock", 32'h1, 32'(rd[0]));
    bus(1'b1, 8'h00, 32'h8012);
    @(negedge hclk);
    chk("lock", 32'h0, 32'(synth_lock));
    bus(1'b1, 8'h00, 32'h8112);
    wlock();
    chk("relock", 32'h1, 32'(synth_lock));
    bus(1'b1, 8'h00, 32'hC112);
    wsrc(2'h1);
    chk("to synth", 32'h1, 32'(n >= 2 && n <= 5));
    bus(1'b1, 8'h04, 32'h2);
    wsrc(2'h2);
    chk("ring", 32'h1, 32'(ring_osc_en));
    bus(1'b1, 8'h04, 32'h1);
    wsrc(2'h3);
    chk("stopped", 32'h3, 32'(clk_src));
    bus(1'b1, 8'h04, 32'h0);
    wsrc(2'h1);
    chk("synth", 32'h1, 32'(clk_src));
    bus(1'b1, 8'h00, 32'h8112);
    wsrc(2'h0);
    chk("from synth", 32'h1, 32'(n >= 12 && n <= 32));
    bus(1'b1, 8'h0C, 32'hFFFFFFFF);
    bus(1'b0, 8'h0C, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b0, 8'h08, 32'h0);
    chk("status src", 32'h0, 32'(rd[2:1]));
    bus(1'b1, 8'h00, 32'h0112);
    @(negedge hclk);
    chk("synth_power", 32'h0, 32'(synth_power));
    bus(1'b1, 8'h00, 32'h8112);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 8'h00, 32'h0);
    chk("pllc", 32'h0, rd);
    chk("synth_power", 32'h0, 32'(synth_power));
    chk("hresp", 32'h0, 32'(hresp));
    test_done();
  end
endmodule : testbench

`default_nettype wire
